/* File: dv/umc_counter_bank_bench.sv */
`timescale 1ns/1ps
module umc_counter_bank_bench;
    import umc_pkg::*;

    logic                         clk = 1'b0;
    logic                         rst_n = 1'b0;
    logic [ADDR_W-1:0]            addr = '0;
    logic [DATA_W-1:0]            wdata = '0;
    logic                         wr = 1'b0;
    logic                         rd = 1'b0;
    logic [DATA_W-1:0]            rdata;
    logic                         run_mode = 1'b0;
    logic                         ce = 1'b1, power_up = 1'b0, power_loss = 1'b0;
    logic [NUM_CNT*VAL_W-1:0]     preset_ext = '0;
    logic [NUM_CNT-1:0]           en, dir, rst, coil;
    logic                         scan_tick, busy, scan_done;
    logic                         rd_seen = 1'b0;
    logic [DATA_W-1:0]            exq[$];
    string                        nmq[$];
    int                           n_fail = 0;
    int                           samples_checked = 0;
    int                           cyc = 0;
    logic [15:0]                  lf = 16'h0061;
    logic [VAL_W-1:0]             ext_exp;

    always #2.5 clk = ~clk;

    umc_counter_bank i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .scan_tick(scan_tick), .run_mode(run_mode), .power_up(power_up), .power_loss(power_loss),
        .bit_operand_source_en(en), .bit_operand_source_dir(dir), .bit_operand_source_rst(rst),
        .preset_ext(preset_ext), .counter_coil_code(coil), .busy(busy), .scan_done(scan_done));

    umc_ladder_model i_lad (.clk(clk), .scan_done(scan_done), .en(en), .dir(dir), .rst(rst), .scan_tick(scan_tick));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic reg_wr(input int i, input logic [FLD_W-1:0] f, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= {IDX_W'(i), f};
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // The expectation is queued as the read is issued; the monitor pops it
    task automatic reg_rd(input string nm, input int i, input logic [FLD_W-1:0] f, input logic [DATA_W-1:0] e);
        @(posedge clk);
        addr <= {IDX_W'(i), f};
        rd   <= 1'b1;
        exq.push_back(e);
        nmq.push_back(nm);
        @(posedge clk);
        rd   <= 1'b0;
    endtask

    always @(posedge clk) rd_seen <= rd;

    // Read data stand only in the cycle after the strobe
    always @(negedge clk) begin
        if (rd_seen) begin
            if (exq.size() == 0) check("read queue", 32'h1, 32'h0);
            else check(nmq.pop_front(), rdata, exq.pop_front());
        end
    end

    task automatic tdone(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic results;
        n_fail = n_fail + i_lad.missed;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        for (int i = 0; i < NUM_CNT * VAL_W / 16; i++) begin
            lf = lfsr(lf);
            preset_ext[i*16 +: 16] = lf;
        end
        ext_exp = (preset_ext[5*VAL_W +: VAL_W] > VAL_MAX) ? VAL_MAX : preset_ext[5*VAL_W +: VAL_W];
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd("cfg reset", 0, FLD_CFG, 32'h0);
        reg_rd("unmapped", 31, 3'h7, 32'h0);
        reg_wr(31, FLD_CTRL, 32'h1);
        reg_rd("retain opt", 31, FLD_CTRL, 32'h1);
        reg_wr(4, FLD_PRESET, 32'h000FFFFF);
        reg_rd("preset clamp", 4, FLD_PRESET, {12'h000, VAL_MAX});
        reg_wr(5, FLD_CFG, 32'h00000010);
        reg_rd("preset live", 5, FLD_PRESET, {12'h000, ext_exp});
        tdone("registers");
        reg_wr(0, FLD_CFG, {28'h0, MODE_FIX_NR});
        reg_wr(0, FLD_PRESET, 32'h3);
        i_lad.step(5);
        reg_rd("fixed stop", 0, FLD_CUR, 32'h3);
        check("coil0 eq", 32'(coil[0]), 32'h1);
        check("coil30 mode0", 32'(coil[30]), 32'h1);
        i_lad.set_ops(31'h1, 31'h0);
        i_lad.step(1);
        reg_rd("down step", 0, FLD_CUR, 32'h2);
        check("coil0 ne", 32'(coil[0]), 32'h0);
        i_lad.set_ops(31'h1, 31'h1);
        i_lad.scan();
        reg_rd("reset clear", 0, FLD_CUR, 32'h0);
        i_lad.set_ops(31'h1, 31'h0);
        i_lad.step(2);
        reg_rd("down floor", 0, FLD_CUR, 32'h0);
        ce <= 1'b0;
        reg_wr(0, FLD_PRESET, 32'h9);
        ce <= 1'b1;
        reg_rd("frozen write", 0, FLD_PRESET, 32'h3);
        tdone("fixed");
        reg_wr(1, FLD_CFG, {28'h0, MODE_CONT_NR});
        reg_wr(1, FLD_PRESET, 32'h2);
        reg_wr(2, FLD_CFG, {28'h0, MODE_UD_NR});
        reg_wr(2, FLD_PRESET, 32'h2);
        reg_wr(3, FLD_CFG, {28'h0, MODE_UD_RT});
        reg_wr(6, FLD_CFG, {28'h0, MODE_FIX_RT});
        reg_wr(7, FLD_CFG, {28'h0, MODE_CONT_RT});
        i_lad.set_ops(31'h0, 31'h0);
        i_lad.step(4);
        reg_rd("past preset", 1, FLD_CUR, 32'h4);
        check("coil1 above", 32'(coil[1]), 32'h0);
        check("coil2 above", 32'(coil[2]), 32'h1);
        check("coil3 zero preset", 32'(coil[3]), 32'h0);
        check("coil7 ge", 32'(coil[7]), 32'h1);
        i_lad.set_ops(31'h4, 31'h0);
        i_lad.step(3);
        reg_rd("updown value", 2, FLD_CUR, 32'h1);
        check("coil2 below", 32'(coil[2]), 32'h0);
        tdone("continuous");
        @(posedge clk);
        run_mode <= 1'b1;
        i_lad.wait_done();
        reg_rd("switch init", 1, FLD_CUR, 32'h0);
        reg_rd("switch zero", 2, FLD_CUR, 32'h0);
        reg_rd("switch keep", 3, FLD_CUR, 32'h7);
        power_loss <= 1'b1;
        @(posedge clk);
        power_loss <= 1'b0;
        power_up   <= 1'b1;
        @(posedge clk);
        power_up   <= 1'b0;
        i_lad.wait_done();
        reg_rd("power keep", 7, FLD_CUR, 32'h7);
        repeat (3) @(posedge clk);
        tdone("run stop");
        results();
    end
endmodule // umc_counter_bank_bench

/* File: dv/umc_ladder_model.sv */
`timescale 1ns/1ps
module umc_ladder_model (
    // Clock and pass completion
    input  wire logic                         clk,
    input  wire logic                         scan_done,
    // Rung operands, one bit per counter
    output logic      [umc_pkg::NUM_CNT-1:0]  en,
    output logic      [umc_pkg::NUM_CNT-1:0]  dir,
    output logic      [umc_pkg::NUM_CNT-1:0]  rst,
    output logic                              scan_tick
);
    import umc_pkg::*;

    int missed = 0;

    initial begin
        en        = '0;
        dir       = '0;
        rst       = '0;
        scan_tick = 1'b0;
    end

    // Operands are held until the pass ends, so the snapshot never sees a change
    task automatic wait_done;
        bit seen;
        seen = 1'b0;
        for (int n = 0; n < 100 && !seen; n++) begin
            @(negedge clk);
            seen = scan_done;
        end
        if (!seen) missed++;
    endtask

    task automatic scan;
        @(posedge clk);
        scan_tick <= 1'b1;
        @(posedge clk);
        scan_tick <= 1'b0;
        wait_done();
    endtask

    task automatic set_ops(input logic [NUM_CNT-1:0] d, input logic [NUM_CNT-1:0] r);
        @(posedge clk);
        dir <= d;
        rst <= r;
    endtask

    // One count per low scan followed by a high scan
    task automatic step(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            en <= '0;
            scan();
            @(posedge clk);
            en <= '1;
            scan();
        end
    endtask
endmodule // umc_ladder_model

/* File: hw/umc_counter_bank.sv */
// How it works
// - Thirty-one counters, each with its own coil.
// - Mode field per counter; fast modes ignored here.
// - Direction low counts up, high counts down.
// - Reset high forces current value to zero.
// - Current and preset stay within 0..999999.
// - Preset is a constant or external live value.
// - Mode 0 coil simply follows enable.
// - Modes 1,3 stop at preset or zero.
// - Modes 1-3 coil on when value equals preset.
// - Modes 1,2 reload initial value on power, switch.
// - Mode 2 counts past preset, stops at zero.
// - Mode 3 keeps running value across power loss.
// - Modes 3,4,6 keep value across switch if retain.
// - Mode 4 keeps running value across power loss.
// - Modes 4-6 coil on while value reaches preset.
// - Modes 5,6 threshold is non-zero preset only.
// - Mode 5 zeroes on reset, power, switch.
// - Mode 6 zeroes on reset, and on power or switch when not kept.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module umc_counter_bank (
    // Clock and reset
    input  wire logic                                      clk,
    input  wire logic                                      rst_n,
    input  wire logic                                      ce,
    // Register port
    input  wire logic [umc_pkg::ADDR_W-1:0]                addr,
    input  wire logic [umc_pkg::DATA_W-1:0]                wdata,
    input  wire logic                                      wr,
    input  wire logic                                      rd,
    output logic      [umc_pkg::DATA_W-1:0]                rdata,
    // System events
    input  wire logic                                      scan_tick,
    input  wire logic                                      run_mode,
    input  wire logic                                      power_up,
    input  wire logic                                      power_loss,
    // Bit operands, one bit per counter
    input  wire logic [umc_pkg::NUM_CNT-1:0]               bit_operand_source_en,
    input  wire logic [umc_pkg::NUM_CNT-1:0]               bit_operand_source_dir,
    input  wire logic [umc_pkg::NUM_CNT-1:0]               bit_operand_source_rst,
    // Live preset values from other functions
    input  wire logic [umc_pkg::NUM_CNT*umc_pkg::VAL_W-1:0] preset_ext,
    // Status
    output logic      [umc_pkg::NUM_CNT-1:0]               counter_coil_code,
    output logic                                           busy,
    output logic                                           scan_done
);
    import umc_pkg::*;

    umc_state_t        state;
    logic [IDX_W-1:0]  walk_idx;
    logic [MODE_W-1:0] mode_reg     [NUM_CNT];
    logic [VAL_W-1:0]  preset_const [NUM_CNT];
    logic [VAL_W-1:0]  cur_val      [NUM_CNT];
    logic [VAL_W-1:0]  eff_preset   [NUM_CNT];
    logic [NUM_CNT-1:0] src_ext;
    logic [NUM_CNT-1:0] prev_en;
    logic [NUM_CNT-1:0] en_snap;
    logic [NUM_CNT-1:0] dir_snap;
    logic [NUM_CNT-1:0] rst_snap;
    logic              retain_opt;
    logic              run_q;
    logic              lost_in_run;
    logic              pend_scan;
    logic              pend_power;
    logic              pend_switch;
    logic              kind_scan;
    logic              kind_power;
    logic              kind_switch;
    logic              take;
    logic              wr_now;
    logic [IDX_W-1:0]  bus_idx;
    logic [FLD_W-1:0]  bus_fld;
    logic              bus_cnt;
    logic [DATA_W-1:0] next_rdata;
    logic [MODE_W-1:0] sel_mode;
    logic [VAL_W-1:0]  sel_cur;
    logic [VAL_W-1:0]  sel_pre;
    logic              sel_rise;
    logic              scan_only;
    logic [VAL_W-1:0]  next_cur;
    logic              next_coil;

    assign bus_idx = addr[ADDR_W-1:FLD_W];
    assign bus_fld = addr[FLD_W-1:0];
    assign bus_cnt = (bus_idx != GLOBAL_IDX);
    assign take    = (state == UMC_IDLE) && (pend_scan || pend_power || pend_switch);
    assign wr_now  = ce && (state == UMC_WALK);
    assign busy      = (state != UMC_IDLE);
    assign scan_done = (state == UMC_DONE);

    // Preset source per counter
    for (genvar g = 0; g < NUM_CNT; g++) begin : g_preset
        assign eff_preset[g] = src_ext[g] ? umc_clamp(preset_ext[g*VAL_W +: VAL_W]) : preset_const[g];
    end

    // Software setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                mode_reg[i]     <= MODE_RST;
                preset_const[i] <= PRESET_RST;
            end
            src_ext    <= '0;
            retain_opt <= RETAIN_RST;
        end else if (ce && wr) begin
            if (bus_cnt && bus_fld == FLD_CFG) begin
                mode_reg[bus_idx] <= wdata[MODE_W-1:0];
                src_ext[bus_idx]  <= wdata[CFG_SRC_BIT];
            end else if (bus_cnt && bus_fld == FLD_PRESET) begin
                preset_const[bus_idx] <= umc_clamp(wdata[VAL_W-1:0]);
            end else if (!bus_cnt && bus_fld == FLD_CTRL) begin
                retain_opt <= wdata[CTRL_RETAIN_BIT];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = '0;
        if (bus_cnt) begin
            case (bus_fld)
                FLD_CFG:    next_rdata = {27'h0000000, src_ext[bus_idx], mode_reg[bus_idx]};
                FLD_PRESET: next_rdata = {12'h000, eff_preset[bus_idx]};
                FLD_CUR:    next_rdata = {12'h000, cur_val[bus_idx]};
                FLD_STAT:   next_rdata = {30'h00000000, prev_en[bus_idx], counter_coil_code[bus_idx]};
                default:    next_rdata = '0;
            endcase
        end else begin
            case (bus_fld)
                FLD_CTRL: next_rdata = {31'h00000000, retain_opt};
                FLD_SYS:  next_rdata = {29'h00000000, busy, lost_in_run, run_q};
                default:  next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= rd ? next_rdata : '0;
        end
    end

    // Event capture; a new event in the take cycle stays pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q       <= 1'b0;
            lost_in_run <= 1'b0;
            pend_scan   <= 1'b0;
            pend_power  <= 1'b0;
            pend_switch <= 1'b0;
        end else if (ce) begin
            run_q       <= run_mode;
            if (power_loss) begin
                lost_in_run <= run_mode;
            end
            pend_scan   <= (pend_scan && !take) || scan_tick;
            pend_power  <= (pend_power && !take) || power_up;
            pend_switch <= (pend_switch && !take) || (run_mode != run_q);
        end
    end

    // Walk sequencer: one counter per cycle, bit operands frozen for the whole walk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= UMC_IDLE;
            walk_idx    <= '0;
            kind_scan   <= 1'b0;
            kind_power  <= 1'b0;
            kind_switch <= 1'b0;
            en_snap     <= '0;
            dir_snap    <= '0;
            rst_snap    <= '0;
        end else if (ce) begin
            case (state)
                UMC_IDLE: begin
                    if (take) begin
                        state       <= UMC_WALK;
                        walk_idx    <= '0;
                        kind_scan   <= pend_scan;
                        kind_power  <= pend_power;
                        kind_switch <= pend_switch;
                        en_snap     <= bit_operand_source_en;
                        dir_snap    <= bit_operand_source_dir;
                        rst_snap    <= bit_operand_source_rst;
                    end
                end
                UMC_WALK: begin
                    if (walk_idx == LAST_IDX) begin
                        state <= UMC_DONE;
                    end else begin
                        walk_idx <= walk_idx + 5'h01;
                    end
                end
                UMC_DONE: state <= UMC_IDLE;
                default:  state <= UMC_IDLE;
            endcase
        end
    end

    assign sel_mode  = mode_reg[walk_idx];
    assign sel_cur   = cur_val[walk_idx];
    assign sel_pre   = eff_preset[walk_idx];
    assign sel_rise  = en_snap[walk_idx] && !prev_en[walk_idx];
    assign scan_only = kind_scan && !kind_power && !kind_switch;

    umc_step u_step (
        .mode        (sel_mode),
        .cur         (sel_cur),
        .preset      (sel_pre),
        .en_level    (en_snap[walk_idx]),
        .en_rise     (sel_rise),
        .dir         (dir_snap[walk_idx]),
        .rst         (rst_snap[walk_idx]),
        .power_evt   (kind_power),
        .switch_evt  (kind_switch),
        .scan_evt    (kind_scan),
        .retain_opt  (retain_opt),
        .lost_in_run (lost_in_run),
        .next_cur    (next_cur),
        .next_coil   (next_coil)
    );

    // Counter state update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                cur_val[i] <= VAL_ZERO;
            end
            counter_coil_code <= '0;
            prev_en           <= '0;
        end else if (wr_now) begin
            cur_val[walk_idx]           <= next_cur;
            counter_coil_code[walk_idx] <= next_coil;
            if (kind_scan) begin
                prev_en[walk_idx] <= en_snap[walk_idx];
            end
        end
    end

    chk_walk_end: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && walk_idx == LAST_IDX) |=> (state == UMC_DONE) ##1 (state == ($past(ce) ? UMC_IDLE : UMC_DONE)))
        else $error("walk did not finish after the last counter");

    chk_value_range: assert property (@(posedge clk) disable iff (!rst_n)
        (state == UMC_WALK) |-> (sel_cur <= VAL_MAX && sel_pre <= VAL_MAX))
        else $error("value beyond 999999");

    chk_reset_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && scan_only && umc_counts(sel_mode) && rst_snap[walk_idx])
        |=> (cur_val[$past(walk_idx)] == VAL_ZERO))
        else $error("reset did not clear the counter");

    chk_up_step: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && scan_only && sel_mode == MODE_CONT_NR && !rst_snap[walk_idx] && sel_rise
         && !dir_snap[walk_idx] && sel_cur < VAL_MAX)
        |=> (cur_val[$past(walk_idx)] == $past(sel_cur) + VAL_ONE))
        else $error("up count step missing");

    chk_down_step: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && scan_only && umc_counts(sel_mode) && !rst_snap[walk_idx] && sel_rise
         && dir_snap[walk_idx] && sel_cur != VAL_ZERO)
        |=> (cur_val[$past(walk_idx)] == $past(sel_cur) - VAL_ONE))
        else $error("down count step missing");

    chk_fixed_stop: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && scan_only && umc_stops_at_preset(sel_mode) && !rst_snap[walk_idx]
         && !dir_snap[walk_idx] && sel_cur == sel_pre)
        |=> (cur_val[$past(walk_idx)] == $past(sel_cur)))
        else $error("fixed counter moved past preset");

    chk_coil_equal: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && sel_mode >= MODE_FIX_NR && sel_mode <= MODE_FIX_RT)
        |=> (counter_coil_code[$past(walk_idx)] == (cur_val[$past(walk_idx)] == $past(sel_pre))))
        else $error("equal coil wrong");

    chk_coil_ge: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && sel_mode >= MODE_CONT_RT && sel_mode <= MODE_UD_RT)
        |=> (counter_coil_code[$past(walk_idx)] == ((cur_val[$past(walk_idx)] >= $past(sel_pre))
             && ($past(sel_mode) == MODE_CONT_RT || $past(sel_pre) != VAL_ZERO))))
        else $error("threshold coil wrong");

    chk_mode0_coil: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && sel_mode == MODE_COIL)
        |=> (counter_coil_code[$past(walk_idx)] == $past(en_snap[walk_idx])))
        else $error("internal coil does not follow enable");

    chk_switch_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && !kind_power && kind_switch && sel_mode == MODE_UD_NR)
        |=> (cur_val[$past(walk_idx)] == VAL_ZERO))
        else $error("mode 5 kept value over RUN/STOP");

    // Walk entry; a low enable must hold every register
    chk_walk_start: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && take)
        |=> (state == UMC_WALK && walk_idx == '0))
        else $error("walk did not start at counter 0");

    chk_freeze_state: assert property (@(posedge clk) disable iff (!rst_n)
        !ce
        |=> ($stable(state) && $stable(walk_idx) && $stable(rdata) && $stable(counter_coil_code)))
        else $error("state moved while enable low");

    chk_rise_only: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && scan_only && umc_counts(sel_mode) && !rst_snap[walk_idx] && !sel_rise)
        |=> (cur_val[$past(walk_idx)] == $past(sel_cur)))
        else $error("count without rising enable");

    chk_en_history: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && kind_scan)
        |=> (prev_en[$past(walk_idx)] == $past(en_snap[walk_idx])))
        else $error("enable history not updated");

    // Power-up and RUN/STOP outcomes
    chk_init_load: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && (kind_power || kind_switch) && (sel_mode == MODE_FIX_NR || sel_mode == MODE_CONT_NR))
        |=> (cur_val[$past(walk_idx)] == ($past(dir_snap[walk_idx]) ? $past(sel_pre) : VAL_ZERO)))
        else $error("initial value not loaded");

    chk_power_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && kind_power && lost_in_run && umc_keeps_on_switch(sel_mode))
        |=> (cur_val[$past(walk_idx)] == $past(sel_cur)))
        else $error("retentive value lost at power-up");

    chk_switch_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && !kind_power && kind_switch && retain_opt && umc_keeps_on_switch(sel_mode))
        |=> (cur_val[$past(walk_idx)] == $past(sel_cur)))
        else $error("retained value lost over RUN/STOP");

    chk_mode5_power: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_now && kind_power && sel_mode == MODE_UD_NR)
        |=> (cur_val[$past(walk_idx)] == VAL_ZERO))
        else $error("mode 5 kept value over power-up");

    chk_loss_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && power_loss)
        |=> (lost_in_run == $past(run_mode)))
        else $error("run state not captured at power loss");

endmodule // umc_counter_bank

/* File: hw/umc_pkg.sv */
package umc_pkg;

    // Bank shape
    localparam int          NUM_CNT  = 31;
    localparam int          IDX_W    = 5;
    localparam int          VAL_W    = 20;
    localparam int          MODE_W   = 4;
    localparam int          ADDR_W   = 8;
    localparam int          DATA_W   = 32;
    localparam int          FLD_W    = 3;

    localparam logic [IDX_W-1:0]  LAST_IDX   = 5'h1E;
    localparam logic [IDX_W-1:0]  GLOBAL_IDX = 5'h1F;
    localparam logic [VAL_W-1:0]  VAL_MAX    = 20'hF423F;
    localparam logic [VAL_W-1:0]  VAL_ONE    = 20'h00001;
    localparam logic [VAL_W-1:0]  VAL_ZERO   = 20'h00000;

    // Counting modes
    localparam logic [MODE_W-1:0] MODE_COIL    = 4'h0;
    localparam logic [MODE_W-1:0] MODE_FIX_NR  = 4'h1;
    localparam logic [MODE_W-1:0] MODE_CONT_NR = 4'h2;
    localparam logic [MODE_W-1:0] MODE_FIX_RT  = 4'h3;
    localparam logic [MODE_W-1:0] MODE_CONT_RT = 4'h4;
    localparam logic [MODE_W-1:0] MODE_UD_NR   = 4'h5;
    localparam logic [MODE_W-1:0] MODE_UD_RT   = 4'h6;

    // Register word address = {counter index, field}
    localparam logic [FLD_W-1:0]  FLD_CFG    = 3'h0;
    localparam logic [FLD_W-1:0]  FLD_PRESET = 3'h1;
    localparam logic [FLD_W-1:0]  FLD_CUR    = 3'h2;
    localparam logic [FLD_W-1:0]  FLD_STAT   = 3'h3;
    localparam logic [FLD_W-1:0]  FLD_CTRL   = 3'h0;
    localparam logic [FLD_W-1:0]  FLD_SYS    = 3'h1;
    localparam int                CFG_SRC_BIT     = 4;
    localparam int                CTRL_RETAIN_BIT = 0;

    // Reset values
    localparam logic [MODE_W-1:0] MODE_RST   = 4'h0;
    localparam logic [VAL_W-1:0]  PRESET_RST = 20'h00000;
    localparam logic              RETAIN_RST = 1'b0;

    typedef enum logic [1:0] {
        UMC_IDLE = 2'b00,
        UMC_WALK = 2'b01,
        UMC_DONE = 2'b11
    } umc_state_t;

    function automatic logic umc_stops_at_preset(input logic [MODE_W-1:0] m);
        return (m == MODE_FIX_NR) || (m == MODE_FIX_RT);
    endfunction

    function automatic logic umc_keeps_on_switch(input logic [MODE_W-1:0] m);
        return (m == MODE_FIX_RT) || (m == MODE_CONT_RT) || (m == MODE_UD_RT);
    endfunction

    function automatic logic umc_counts(input logic [MODE_W-1:0] m);
        return (m >= MODE_FIX_NR) && (m <= MODE_UD_RT);
    endfunction

    function automatic logic [VAL_W-1:0] umc_clamp(input logic [VAL_W-1:0] v);
        return (v > VAL_MAX) ? VAL_MAX : v;
    endfunction

endpackage

/* File: hw/umc_step.sv */
`timescale 1ns/1ps
module umc_step (
    // Counter state and setup
    input  wire logic [umc_pkg::MODE_W-1:0] mode,
    input  wire logic [umc_pkg::VAL_W-1:0]  cur,
    input  wire logic [umc_pkg::VAL_W-1:0]  preset,
    // Operands of this scan
    input  wire logic                       en_level,
    input  wire logic                       en_rise,
    input  wire logic                       dir,
    input  wire logic                       rst,
    // Events
    input  wire logic                       power_evt,
    input  wire logic                       switch_evt,
    input  wire logic                       scan_evt,
    input  wire logic                       retain_opt,
    input  wire logic                       lost_in_run,
    // Result
    output logic      [umc_pkg::VAL_W-1:0]  next_cur,
    output logic                            next_coil
);
    import umc_pkg::*;

    always_comb begin
        logic [VAL_W-1:0] init_val;
        init_val = dir ? preset : VAL_ZERO;
        next_cur = cur;
        if (power_evt) begin
            case (mode)
                MODE_FIX_NR, MODE_CONT_NR: next_cur = init_val;
                MODE_FIX_RT, MODE_CONT_RT: next_cur = lost_in_run ? cur : init_val;
                MODE_UD_RT:                next_cur = lost_in_run ? cur : VAL_ZERO;
                MODE_UD_NR:                next_cur = VAL_ZERO;
                default:                   next_cur = cur;
            endcase
        end else if (switch_evt) begin
            case (mode)
                MODE_FIX_NR, MODE_CONT_NR: next_cur = init_val;
                MODE_UD_NR:                next_cur = VAL_ZERO;
                MODE_UD_RT:                next_cur = retain_opt ? cur : VAL_ZERO;
                default: begin
                    if (umc_keeps_on_switch(mode) && retain_opt) begin
                        next_cur = cur;
                    end else if (umc_keeps_on_switch(mode)) begin
                        next_cur = init_val;
                    end else begin
                        next_cur = cur;
                    end
                end
            endcase
        end else if (scan_evt && umc_counts(mode)) begin
            if (rst) begin
                next_cur = VAL_ZERO;
            end else if (en_rise) begin
                if (!dir) begin
                    if (umc_stops_at_preset(mode)) begin
                        if (cur < preset) begin
                            next_cur = cur + VAL_ONE;
                        end
                    end else if (cur < VAL_MAX) begin
                        next_cur = cur + VAL_ONE;
                    end
                end else if (cur != VAL_ZERO) begin
                    next_cur = cur - VAL_ONE;
                end
            end
        end
        case (mode)
            MODE_COIL:                             next_coil = en_level;
            MODE_FIX_NR, MODE_CONT_NR, MODE_FIX_RT: next_coil = (next_cur == preset);
            MODE_CONT_RT:                          next_coil = (next_cur >= preset);
            MODE_UD_NR, MODE_UD_RT:                next_coil = (preset != VAL_ZERO) && (next_cur >= preset);
            default:                               next_coil = 1'b0;
        endcase
    end

endmodule // umc_step
